// ===== tb/sfcr_device_asserts.sv
// Assertions on the ports of the flash read front end.
// Counters clear while cs_n is high, so sck may toggle outside frames; bound to sfcr_device below.
`include "sfcr_cfg.svh"
module sfcr_device_asserts (
    input wire logic                     clk,
    input wire logic                     resetn,
    input wire logic                     cs_n,
    input wire logic                     sck,
    input wire logic                     si,
    input wire logic                     so,
    input wire logic                     so_oe,
    input wire logic                     page_binary,
    input wire logic                     prog_valid,
    input wire sfcr_pkg::sfcr_prog_req_s prog_req,
    input wire logic                     prog_ready,
    input wire logic                     read_active
);
    import sfcr_pkg::*;
    logic [6:0] cnt;
    logic [7:0] op;
    logic [6:0] first;
    logic       known;
    logic       take;
    // Rising edges and opcode seen in this frame
    always_ff @(posedge sck or posedge cs_n or negedge resetn) begin
        if (!resetn || cs_n) cnt <= 7'h00;
        else if (cnt != `SFCR_CNT_MAX) cnt <= cnt + 7'h01;
    end
    always_ff @(posedge sck or posedge cs_n or negedge resetn) begin
        if (!resetn || cs_n) op <= 8'h00;
        else if (cnt < `SFCR_OPCODE_BITS) op <= {op[6:0], si};
    end
    assign known = op == `SFCR_OP_SLOW || op == `SFCR_OP_FAST || op == `SFCR_OP_LEGACY;
    assign first = op == `SFCR_OP_FAST ? 7'h28 : op == `SFCR_OP_LEGACY ? 7'h40 : 7'h20;
    assign take  = prog_valid && prog_ready;

    early_quiet_a: assert property (@(posedge sck) disable iff (!resetn || cs_n)
        (cnt < first || !known) |-> !so_oe) else $error("output before data phase");
    stream_start_a: assert property (@(posedge sck) disable iff (!resetn || cs_n)
        (known && cnt == first) |-> so_oe) else $error("data phase not started");
    stream_hold_a: assert property (@(posedge sck) disable iff (!resetn || cs_n)
        so_oe |=> so_oe [*2]) else $error("stream broke off");
    desel_float_a: assert property (@(posedge clk) disable iff (!resetn)
        cs_n |-> !so_oe) else $error("output driven while deselected");
    active_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        cs_n [*3] |-> !read_active) else $error("read flag not cleared");
    active_cause_a: assert property (@(posedge clk) disable iff (!resetn)
        $rose(read_active) |-> $past(cs_n, 2) == 1'b0) else $error("read flag without frame");
    erase_busy_a: assert property (@(posedge clk) disable iff (!resetn)
        (take && prog_req.op == SFCR_PROG_PAGE_ERASE) |=> !prog_ready [*8] ##[248:257] prog_ready)
        else $error("page erase length wrong");
    write_quick_a: assert property (@(posedge clk) disable iff (!resetn)
        (take && prog_req.op == SFCR_PROG_WRITE) |=> prog_ready) else $error("write stalled");
    reset_idle_a: assert property (@(posedge clk)
        !resetn |-> !so_oe && prog_ready && !read_active) else $error("not idle in reset");

    cover property (@(posedge sck) known && cnt == first);
    cover property (@(posedge clk) take && prog_req.op == SFCR_PROG_PAGE_ERASE);
    cover property (@(posedge clk) $rose(read_active));
endmodule : sfcr_device_asserts

bind sfcr_device sfcr_device_asserts sfcr_device_asserts_i (
    .clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
    .page_binary(page_binary), .prog_valid(prog_valid), .prog_req(prog_req),
    .prog_ready(prog_ready), .read_active(read_active));

// ===== tb/sfcr_host.sv
// Host controller model: frames reads on the serial link.
// Assumes the bench calls frame() and then reads rx.
module sfcr_host (
    output logic     cs_n,
    output logic     sck,
    output logic     si,
    input wire logic so
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx [$];
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // Set si on the falling edge, sample so on the rising edge
    task automatic bit_x(input logic b, output logic q);
        sck = 1'b0;
        si  = b;
        #24 sck = 1'b1;
        q = so;
        #24;
    endtask : bit_x
    // Opcode, address, dummies, then bytes, msb first
    task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int nd, input int nb,
                         input logic m3);
        logic [31:0] hdr;
        logic        q;
        logic [7:0]  by;
        hdr = {op, ad};
        rx.delete();
        #7;
        repeat (2) bit_x(~si, q); // Deselected clocks, ignored
        sck = m3;
        #24 cs_n = 1'b0;
        #24;
        for (int i = 31; i >= 0; i--) bit_x(hdr[i], q);
        repeat (nd * 8) bit_x(~si, q); // Dummy bytes
        for (int n = 0; n < nb; n++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_x(~si, q);
                by[i] = q;
            end
            rx.push_back(by);
        end
        sck = m3;
        #24 cs_n = 1'b1;
        si = ~si;
    endtask : frame
endmodule : sfcr_host

// ===== tb/sfcr_tb_top.sv
// Bench of the flash read front end: fills the array, streams it back.
// Assumes sfcr_host drives the link and the checker is bound.
`include "sfcr_cfg.svh"
module sfcr_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sfcr_pkg::*;
    logic           clk, resetn, page_binary, prog_valid, prog_ready, read_active;
    logic           cs_n, sck, si, so, so_oe;
    sfcr_prog_req_s prog_req;
    wire            so_pin = so_oe ? so : 1'bz;
    int             err_count = 0;
    int             cmp_count = 0;
    sfcr_device sfcr_device_i (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe(so_oe), .page_binary(page_binary), .prog_valid(prog_valid), .prog_req(prog_req),
        .prog_ready(prog_ready), .read_active(read_active));
    sfcr_host sfcr_host_i (.cs_n(cs_n), .sck(sck), .si(si), .so(so_pin));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #300us;
        err_count++;
        results();
    end
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] pat(input int p, input int o);
        return 8'(p * 5 + o * 3) ^ 8'ha5;
    endfunction : pat
    task automatic wr(input int p, input int o, input sfcr_prog_op_e op);
        prog_req   <= '{op, 10'(p), 9'(o), pat(p, o)};
        prog_valid <= 1'b1;
        @(posedge clk);
    endtask : wr
    task automatic idle();
        prog_valid <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk);
            if (prog_ready === 1'b1) break;
        end
        @(posedge clk);
    endtask : idle
    task automatic rd(input logic [7:0] op, input logic [23:0] ad, input int nd, input logic m3,
                      input logic [7:0] e [$]);
        sfcr_host_i.frame(op, ad, nd, e.size(), m3);
        foreach (e[i]) chk(sfcr_host_i.rx[i], e[i]);
        #2;
        chk({8{so_pin}}, 8'hzz);
        @(posedge clk);
    endtask : rd
    task automatic t_fill();
        int pg [7] = '{3, 3, 4, 4, 1023, 0, 0};
        int of [7] = '{262, 263, 0, 1, 263, 0, 1};
        foreach (pg[i]) wr(pg[i], of[i], SFCR_PROG_WRITE);
        idle();
        $display("fill done");
    endtask : t_fill
    task automatic t_slow();
        rd(`SFCR_OP_SLOW, {5'h1f, 10'd3, 9'd262}, 0, 1'b0,
           '{pat(3, 262), pat(3, 263), pat(4, 0), pat(4, 1)});
        $display("slow read done");
    endtask : t_slow
    task automatic t_fast();
        rd(`SFCR_OP_FAST, {5'h00, 10'd1023, 9'd263}, 1, 1'b1,
           '{pat(1023, 263), pat(0, 0), pat(0, 1)});
        $display("fast read done");
    endtask : t_fast
    task automatic t_legacy();
        rd(`SFCR_OP_LEGACY, {5'h0a, 10'd0, 9'd0}, 4, 1'b0, '{pat(0, 0), pat(0, 1)});
        $display("legacy read done");
    endtask : t_legacy
    task automatic t_bad();
        rd(8'h5a, 24'h000000, 0, 1'b0, '{8'hzz, 8'hzz});
        $display("unknown opcode done");
    endtask : t_bad
    task automatic t_erase();
        wr(4, 0, SFCR_PROG_PAGE_ERASE);
        idle();
        rd(`SFCR_OP_SLOW, {5'h00, 10'd3, 9'd263}, 0, 1'b0, '{pat(3, 263), 8'hff, 8'hff});
        $display("erase done");
    endtask : t_erase
    task automatic t_bin();
        page_binary <= 1'b1;
        repeat (3) @(posedge clk);
        wr(2, 255, SFCR_PROG_WRITE);
        wr(3, 0, SFCR_PROG_WRITE);
        idle();
        rd(`SFCR_OP_SLOW, {6'h3f, 10'd2, 8'd255}, 0, 1'b1, '{pat(2, 255), pat(3, 0)});
        $display("binary read done");
    endtask : t_bin
    task automatic t_reset();
        wr(5, 0, SFCR_PROG_PAGE_ERASE);
        prog_valid <= 1'b0;
        resetn     <= 1'b0;
        @(negedge clk);
        chk({so_oe, prog_ready, read_active, 5'h00}, 8'h40);
        @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        $display("reset done");
    endtask : t_reset
    initial begin
        resetn      = 1'b0;
        page_binary = 1'b0;
        prog_valid  = 1'b0;
        prog_req    = '0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_fill();
        t_slow();
        t_fast();
        t_legacy();
        t_bad();
        t_erase();
        t_bin();
        t_reset();
        results();
    end
endmodule : sfcr_tb_top

// ===== verilog/sfcr_cfg.svh
// Constants for the serial flash continuous read front end.
// Assumes inclusion by the package, the design module, the checker and the bench top.
`ifndef SFCR_CFG_SVH
`define SFCR_CFG_SVH

// Opcodes of the continuous main-array reads
`define SFCR_OP_LEGACY      8'he8
`define SFCR_OP_FAST        8'h0b
`define SFCR_OP_SLOW        8'h03

// Dummy bytes after the address, per read variant
`define SFCR_DUMMY_LEGACY   3'h4
`define SFCR_DUMMY_FAST     3'h1
`define SFCR_DUMMY_SLOW     3'h0

// Frame bit positions
`define SFCR_OPCODE_BITS    7'h08
`define SFCR_ADDR_END       7'h20
`define SFCR_CNT_MAX        7'h7f

// Array geometry
`define SFCR_PAGES          1024
`define SFCR_STD_PAGE_BYTES 264
`define SFCR_BIN_PAGE_BYTES 256
`define SFCR_LAST_PAGE      10'h3ff
`define SFCR_STD_LAST_BYTE  9'h107
`define SFCR_BIN_LAST_BYTE  9'h0ff
`define SFCR_ARRAY_BYTES    270336
`define SFCR_ERASED         8'hff

// Address field positions within the three address bytes
`define SFCR_STD_PAGE_LSB   9
`define SFCR_BIN_PAGE_LSB   8

`endif

// ===== verilog/sfcr_device.sv
// Serial flash device: continuous main-array read over the serial link, plus array store.
// Assumes cs_n, sck and si come from an external host pin, sck idle high or low;
// programming requests arrive on clk from local logic.
//
// Contract
// [RULE1] A frame opens with chip select falling, then opcode and address.
// [RULE2] Opcode, address and data move most significant bit first.
// [RULE3] Locations are three address bytes mixing dummy and real bits.
// [RULE4] Standard pages: 10-bit page then 9-bit byte offset.
// [RULE5] Standard pages: nine-bit buffer offset selects a buffer byte.
// [RULE6] Binary pages: eight-bit offset, upper ten bits select page.
// [RULE7] Opcode e8h takes address and four dummy bytes, then streams.
// [RULE8] Opcode 0bh takes address and one dummy byte, then streams.
// [RULE9] Opcode 03h streams right after the last address bit.
// [RULE10] Host holds chip select low throughout the whole read.
// [RULE11] Internal read pointer loads from start address and auto-increments.
// [RULE12] Page end continues at next page with no delay.
// [RULE13] Array end wraps to the first page with no delay.
// [RULE14] Chip select rising ends the read and floats the output.
// [RULE15] Reads come straight from the array, buffer untouched.
// [RULE16] Hosts should prefer 0bh or 03h over the legacy opcode.
// [RULE17] Link works with clock mode 0 or mode 3.
// [RULE18] Array supports byte or page program and page or chip erase. The engine here has byte write, page erase and chip erase, but no page program.
// [RULE19] Inputs sampled on rising clock, output changes on falling clock.
// [RULE20] While deselected the output floats and input is ignored.
// [RULE21] Reset low aborts everything and idles the machine.
// [RULE22] Leading dummy address bits are ignored.
`include "sfcr_cfg.svh"

module sfcr_device (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    cs_n,
    input  wire logic                    sck,
    input  wire logic                    si,
    output logic                         so,
    output logic                         so_oe,
    input  wire logic                    page_binary,
    input  wire logic                    prog_valid,
    input  wire sfcr_pkg::sfcr_prog_req_s prog_req,
    output logic                         prog_ready,
    output logic                         read_active
);
    import sfcr_pkg::*;

    localparam int IDX_W = 19;

    // Main array, written on clk and read on the link clock
    logic [7:0]       mem [0:`SFCR_ARRAY_BYTES-1];

    // Link side
    logic             link_rst_n;
    logic [6:0]       bit_cnt;
    logic [7:0]       opcode;
    logic [23:0]      addr;
    sfcr_cmd_e        cmd;
    sfcr_cmd_e        next_cmd;
    logic [6:0]       start_cnt;
    logic             data_phase;
    logic             bin_meta;
    logic             bin_link;
    logic             started;
    logic [9:0]       cur_page;
    logic [8:0]       cur_byte;
    logic [2:0]       bit_idx;
    logic [9:0]       start_page;
    logic [8:0]       start_byte;
    logic [9:0]       base_page;
    logic [8:0]       base_byte;
    logic [2:0]       bit_now;
    logic [8:0]       last_byte;
    logic [9:0]       next_page;
    logic [8:0]       next_byte;
    logic [IDX_W-1:0] rd_idx;
    logic [7:0]       rd_byte;

    // Core side
    sfcr_state_e      state;
    logic [IDX_W-1:0] erase_idx;
    logic [IDX_W-1:0] erase_end;
    logic             wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [7:0]       wr_data;
    logic [IDX_W-1:0] req_idx;
    logic [IDX_W-1:0] page_base;
    logic [IDX_W-1:0] page_len;
    logic             act_meta;

    // Deselect or reset clears all frame state at once
    assign link_rst_n = resetn & ~cs_n; // [RULE14] [RULE20] [RULE21]

    // Page size level, static during frames, brought onto the link clock
    always_ff @(posedge sck or negedge resetn) begin
        if (!resetn) begin
            bin_meta <= 1'b0;
            bin_link <= 1'b0;
        end else begin
            bin_meta <= page_binary;
            bin_link <= bin_meta;
        end
    end

    // Opcode decode
    always_comb begin
        case ({opcode[6:0], si})
            `SFCR_OP_LEGACY: next_cmd = SFCR_CMD_LEGACY; // [RULE7]
            `SFCR_OP_FAST:   next_cmd = SFCR_CMD_FAST;   // [RULE8]
            `SFCR_OP_SLOW:   next_cmd = SFCR_CMD_SLOW;   // [RULE9]
            default:         next_cmd = SFCR_CMD_NONE;
        endcase
    end

    // Bit position of the last header bit before data
    always_comb begin
        case (cmd)
            SFCR_CMD_LEGACY: start_cnt = `SFCR_ADDR_END - 7'h01 + {1'b0, `SFCR_DUMMY_LEGACY, 3'h0}; // [RULE7]
            SFCR_CMD_FAST:   start_cnt = `SFCR_ADDR_END - 7'h01 + {1'b0, `SFCR_DUMMY_FAST, 3'h0};   // [RULE8]
            SFCR_CMD_SLOW:   start_cnt = `SFCR_ADDR_END - 7'h01 + {1'b0, `SFCR_DUMMY_SLOW, 3'h0};   // [RULE9]
            default:         start_cnt = `SFCR_CNT_MAX;
        endcase
    end

    // Header bit counter, saturating
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt <= 7'h00; // [RULE1]
        end else if (bit_cnt != `SFCR_CNT_MAX) begin
            bit_cnt <= bit_cnt + 7'h01; // [RULE19]
        end
    end

    // Opcode shift, msb first
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            opcode <= 8'h00;
        end else if (bit_cnt < `SFCR_OPCODE_BITS) begin
            opcode <= {opcode[6:0], si}; // [RULE1] [RULE2]
        end
    end

    // Address shift, msb first
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            addr <= 24'h000000;
        end else if (bit_cnt >= `SFCR_OPCODE_BITS && bit_cnt < `SFCR_ADDR_END) begin
            addr <= {addr[22:0], si}; // [RULE2] [RULE3]
        end
    end

    // Command capture
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cmd <= SFCR_CMD_NONE;
        end else if (bit_cnt == `SFCR_OPCODE_BITS - 7'h01) begin
            cmd <= next_cmd;
        end
    end

    // Data phase opens after the last address or dummy bit
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            data_phase <= 1'b0;
        end else if (cmd != SFCR_CMD_NONE && bit_cnt == start_cnt) begin
            data_phase <= 1'b1; // [RULE7] [RULE8] [RULE9]
        end
    end

    // Start address split, leading bits dropped
    always_comb begin
        if (bin_link) begin
            start_page = addr[`SFCR_BIN_PAGE_LSB +: 10];  // [RULE6] [RULE22]
            start_byte = {1'b0, addr[7:0]};               // [RULE6]
            last_byte  = `SFCR_BIN_LAST_BYTE;
        end else begin
            start_page = addr[`SFCR_STD_PAGE_LSB +: 10];  // [RULE4] [RULE22]
            start_byte = addr[8:0];                       // [RULE4] [RULE5]
            last_byte  = `SFCR_STD_LAST_BYTE;
        end
    end

    // Read pointer and its advance
    always_comb begin
        base_page = started ? cur_page : start_page; // [RULE11]
        base_byte = started ? cur_byte : start_byte;
        bit_now   = started ? bit_idx : 3'h7;        // [RULE2]
        if (base_byte >= last_byte) begin
            next_byte = 9'h000;                      // [RULE12]
            if (base_page == `SFCR_LAST_PAGE) begin
                next_page = 10'h000;                 // [RULE13]
            end else begin
                next_page = base_page + 10'h001;     // [RULE12]
            end
        end else begin
            next_byte = base_byte + 9'h001;          // [RULE11]
            next_page = base_page;
        end
    end

    // Array fetch direct, no buffer in the path
    always_comb begin
        if (bin_link) begin
            rd_idx = {1'b0, base_page, base_byte[7:0]};
        end else begin
            rd_idx = IDX_W'(base_page * `SFCR_STD_PAGE_BYTES) + {10'h000, base_byte};
        end
        if (rd_idx < IDX_W'(`SFCR_ARRAY_BYTES)) begin
            rd_byte = mem[rd_idx]; // [RULE15]
        end else begin
            rd_byte = `SFCR_ERASED;
        end
    end

    // Stream started flag
    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            started <= 1'b0;
        end else if (data_phase) begin
            started <= 1'b1;
        end
    end

    // Bit position within the current byte
    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_idx <= 3'h7;
        end else if (data_phase) begin
            bit_idx <= bit_now - 3'h1; // [RULE2]
        end
    end

    // Read pointer, advanced after the last bit of each byte
    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cur_page <= 10'h000;
            cur_byte <= 9'h000;
        end else if (data_phase) begin
            if (bit_now == 3'h0) begin
                cur_page <= next_page; // [RULE12] [RULE13]
                cur_byte <= next_byte;
            end else begin
                cur_page <= base_page;
                cur_byte <= base_byte;
            end
        end
    end

    // Output stream, changes on falling edges
    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            so    <= 1'b0;
            so_oe <= 1'b0; // [RULE14] [RULE20]
        end else if (data_phase) begin
            so    <= rd_byte[bit_now]; // [RULE19] [RULE17]
            so_oe <= 1'b1;
        end
    end

    // Read activity level brought to the core clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_meta    <= 1'b0;
            read_active <= 1'b0;
        end else begin
            act_meta    <= started;
            read_active <= act_meta;
        end
    end

    // Program and erase engine on the core clock
    assign prog_ready = (state == SFCR_ST_IDLE);

    always_comb begin
        if (page_binary) begin
            page_base = {1'b0, prog_req.page, 8'h00};
            page_len  = IDX_W'(`SFCR_BIN_PAGE_BYTES);
            req_idx   = {1'b0, prog_req.page, prog_req.offset[7:0]};
        end else begin
            page_base = IDX_W'(prog_req.page * `SFCR_STD_PAGE_BYTES);
            page_len  = IDX_W'(`SFCR_STD_PAGE_BYTES);
            req_idx   = page_base + {10'h000, prog_req.offset};
        end
    end

    // Erase span
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            erase_idx <= '0;
            erase_end <= '0;
        end else if (state == SFCR_ST_ERASE) begin
            erase_idx <= erase_idx + IDX_W'(1);
        end else if (prog_valid && prog_req.op == SFCR_PROG_PAGE_ERASE) begin
            erase_idx <= page_base; // [RULE18]
            erase_end <= page_base + page_len - IDX_W'(1);
        end else if (prog_valid && prog_req.op == SFCR_PROG_CHIP_ERASE) begin
            erase_idx <= '0; // [RULE18]
            erase_end <= IDX_W'(`SFCR_ARRAY_BYTES - 1);
        end
    end

    // Engine state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= SFCR_ST_IDLE; // [RULE21]
        end else begin
            case (state)
                SFCR_ST_IDLE: begin
                    if (prog_valid && prog_req.op == SFCR_PROG_PAGE_ERASE) begin
                        state <= SFCR_ST_ERASE; // [RULE18]
                    end else if (prog_valid && prog_req.op == SFCR_PROG_CHIP_ERASE) begin
                        state <= SFCR_ST_ERASE; // [RULE18]
                    end
                end
                SFCR_ST_ERASE: begin
                    if (erase_idx == erase_end) begin
                        state <= SFCR_ST_IDLE;
                    end
                end
                default: begin
                    state <= SFCR_ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        wr_en   = 1'b0;
        wr_idx  = req_idx;
        wr_data = prog_req.data;
        if (state == SFCR_ST_ERASE) begin
            wr_en   = 1'b1;
            wr_idx  = erase_idx;
            wr_data = `SFCR_ERASED;
        end else if (prog_valid && prog_req.op == SFCR_PROG_WRITE) begin
            wr_en = 1'b1; // [RULE18]
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en && wr_idx < IDX_W'(`SFCR_ARRAY_BYTES)) begin
            mem[wr_idx] <= wr_data;
        end
    end

endmodule : sfcr_device

// ===== verilog/sfcr_pkg.sv
// Types for the serial flash continuous read front end.
// Assumes sfcr_cfg.svh is on the include path.
`include "sfcr_cfg.svh"

package sfcr_pkg;

    typedef enum logic [1:0] {
        SFCR_CMD_NONE   = 2'b00,
        SFCR_CMD_LEGACY = 2'b01,
        SFCR_CMD_FAST   = 2'b10,
        SFCR_CMD_SLOW   = 2'b11
    } sfcr_cmd_e;

    typedef enum logic [1:0] {
        SFCR_PROG_WRITE      = 2'b00,
        SFCR_PROG_PAGE_ERASE = 2'b01,
        SFCR_PROG_CHIP_ERASE = 2'b10
    } sfcr_prog_op_e;

    typedef enum logic [1:0] {
        SFCR_ST_IDLE  = 2'b00,
        SFCR_ST_ERASE = 2'b01
    } sfcr_state_e;

    typedef struct packed {
        sfcr_prog_op_e op;
        logic [9:0]    page;
        logic [8:0]    offset;
        logic [7:0]    data;
    } sfcr_prog_req_s;

endpackage : sfcr_pkg
